// ---- rtl/fgam_flash_guard.sv ----
// Flash write guard, area remapping and standby reset control
// What this block does
// - Guard value 101 plus key enables commands
// - Disabled guard ignores command writes and toggling
// - Guard resets to 010, disabled
// - Disabling rejects new writes, running sequence continues
// - Flash commands pass only through data space
// - Area 10 plus key shows code window
// - Area 00 plus key restores standard mapping
// - Both windows alias same cells; program once
// - RAM-map bit plus key D4 maps RAM
// - Serial mode always maps RAM into code
// - Boot bit plus key overlays boot ROM
// - Boot bit 0 plus key removes overlay
// - Serial mode fixes boot ROM in both spaces
// - Serial mode boot bit reads 1, ignores writes
// - Standby bit writable only from RAM code
// - Flash access with standby bit raises reset
// - Interrupt with flash vectors clears standby bit
// - RAM vectors keep bit; flash target resets
// - Controls double-buffered; key commits; mirror reads active
// - Standby control register reads all zeros
// - Busy flash toggles bit 6 per read
`timescale 1ns/1ps
`default_nettype none
module fgam_flash_guard (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_mode,
    input wire logic exec_from_ram,
    input wire logic irq_vector_fetch,
    input wire logic code_req,
    input wire logic [15:0] code_addr,
    output logic code_to_flash,
    output logic code_to_boot,
    output logic code_to_ram,
    input wire logic data_req,
    input wire logic data_we,
    input wire logic [15:0] data_addr,
    input wire logic [7:0] data_wdata,
    output logic data_to_flash,
    output logic data_to_boot,
    output logic [7:0] data_rdata,
    output logic data_rvalid,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_busy,
    output logic flash_cmd_we,
    output logic [15:0] flash_cmd_addr,
    output logic [7:0] flash_cmd_data,
    output logic flash_code_win,
    output logic guard_enabled,
    output logic standby_bit,
    output logic standby_reset
);
    function automatic logic in_range(input logic [15:0] a,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic hit(input logic [15:0] a,
                                 input logic [13:0] idx);
        hit = (a[15:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    // Bus decode
    wire logic access = psel && penable;
    wire logic bus_wr = access && pwrite;
    wire logic sel_ctrl = hit(paddr, fgam_pkg::IDX_CTRL_ONE);
    wire logic sel_commit = hit(paddr, fgam_pkg::IDX_COMMIT);
    wire logic sel_sleep = hit(paddr, fgam_pkg::IDX_SLEEP_CTRL);
    wire logic sel_sys = hit(paddr, fgam_pkg::IDX_SYS_CFG_THREE);
    wire logic sel_sys_commit = hit(paddr, fgam_pkg::IDX_SYS_COMMIT);
    wire logic sel_any = sel_ctrl || sel_commit || sel_sleep ||
                         sel_sys || sel_sys_commit;

    assign pready = 1'b1;
    assign pslverr = access && !sel_any;

    // Flash control: holding copy and active copy
    logic [7:0] ctrl_hold;
    logic [7:0] ctrl_act;
    logic [7:0] next_ctrl_hold;
    wire logic ctrl_wr = bus_wr && sel_ctrl;
    wire logic flash_commit = bus_wr && sel_commit &&
                              (pwdata[7:0] == fgam_pkg::FLASH_KEY);

    // In serial mode the boot bit keeps its held value on writes
    always_comb begin
        next_ctrl_hold = pwdata[7:0];
        if (serial_mode) begin
            next_ctrl_hold[fgam_pkg::BOOT_BIT] =
                ctrl_hold[fgam_pkg::BOOT_BIT];
        end
    end

    fgam_shadow_reg #(
        .W(8),
        .RST(fgam_pkg::CTRL_ONE_RST)
    ) u_ctrl_one (
        .clk(pclk),
        .rstn(presetn),
        .wr_hold(ctrl_wr),
        .hold_in(next_ctrl_hold),
        .commit(flash_commit),
        .hold(ctrl_hold),
        .active(ctrl_act)
    );

    // System config: RAM map and vector location, committed by key D4
    logic [1:0] sys_hold;
    logic [1:0] sys_act;
    wire logic sys_wr = bus_wr && sel_sys;
    wire logic sys_commit = bus_wr && sel_sys_commit &&
                            (pwdata[7:0] == fgam_pkg::SYS_KEY);

    fgam_shadow_reg #(
        .W(2),
        .RST(fgam_pkg::SYS_CFG_RST)
    ) u_sys_cfg (
        .clk(pclk),
        .rstn(presetn),
        .wr_hold(sys_wr),
        .hold_in(pwdata[1:0]),
        .commit(sys_commit),
        .hold(sys_hold),
        .active(sys_act)
    );

    // Decoded active controls
    wire logic [2:0] guard_act =
        ctrl_act[fgam_pkg::GUARD_HI:fgam_pkg::GUARD_LO];
    // Reserved guard codes count as disabled, the safe side
    wire logic guard_on = (guard_act == fgam_pkg::GUARD_ON);
    wire logic [1:0] area_act =
        ctrl_act[fgam_pkg::AREA_HI:fgam_pkg::AREA_LO];
    wire logic area_code = (area_act == fgam_pkg::AREA_CODE);
    wire logic boot_on = serial_mode ||
                         ctrl_act[fgam_pkg::BOOT_BIT];
    wire logic ram_on = serial_mode ||
                        sys_act[fgam_pkg::RAM_MAP_BIT];
    wire logic vec_in_ram = sys_act[fgam_pkg::VEC_RAM_BIT];

    assign guard_enabled = guard_on;
    assign flash_code_win = area_code;

    // Code space map
    wire logic [15:0] boot_code_hi = serial_mode ?
        fgam_pkg::BOOT_SER_CODE_HI : fgam_pkg::BOOT_HI;
    wire logic code_boot_hit = boot_on &&
        in_range(code_addr, fgam_pkg::BOOT_LO, boot_code_hi);
    wire logic code_ram_hit = ram_on && in_range(code_addr,
        fgam_pkg::RAM_CODE_LO, fgam_pkg::RAM_CODE_HI);
    wire logic code_flash_hit = in_range(code_addr,
        fgam_pkg::FLASH_LO, fgam_pkg::FLASH_HI);

    assign code_to_boot = code_req && code_boot_hit;
    assign code_to_ram = code_req && code_ram_hit;
    assign code_to_flash = code_req && code_flash_hit;

    // Data space map
    wire logic data_boot_hit = boot_on && in_range(data_addr,
        fgam_pkg::BOOT_LO, fgam_pkg::BOOT_HI);
    wire logic data_flash_hit = in_range(data_addr,
        fgam_pkg::FLASH_LO, fgam_pkg::FLASH_HI);

    assign data_to_boot = data_req && data_boot_hit;
    assign data_to_flash = data_req && data_flash_hit;

    // Command writes reach flash only from data space and only with the
    // guard open. A sequence already in the engine is left alone when
    // the guard closes; the engine itself owns its progress.
    wire logic cmd_write = data_to_flash && data_we &&
                           guard_on;
    wire logic flash_read = data_to_flash && !data_we;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cmd_we <= 1'b0;
        end else begin
            flash_cmd_we <= cmd_write;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cmd_addr <= 16'h0000;
            flash_cmd_data <= 8'h00;
        end else if (cmd_write) begin
            flash_cmd_addr <= data_addr;
            flash_cmd_data <= data_wdata;
        end
    end

    // Toggle bit while the array is busy; frozen when the guard is shut
    logic toggle;
    wire logic busy_toggle = flash_busy && guard_on;
    wire logic [7:0] flash_view = busy_toggle ?
        {flash_rdata[7], toggle, flash_rdata[5:0]} : flash_rdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle <= 1'b0;
        end else if (flash_read && busy_toggle) begin
            toggle <= !toggle;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_rdata <= 8'h00;
            data_rvalid <= 1'b0;
        end else begin
            data_rvalid <= flash_read;
            if (flash_read) begin
                data_rdata <= flash_view;
            end
        end
    end

    // Standby reset bit
    wire logic irq_clear = irq_vector_fetch && !vec_in_ram;
    wire logic sleep_wr = bus_wr && sel_sleep &&
                          exec_from_ram;
    // Flash fetches and data accesses both count; with vectors in RAM a
    // handler placed in flash lands here on its first fetch.
    wire logic flash_touch = code_to_flash || data_to_flash;
    logic next_standby;

    always_comb begin
        next_standby = standby_bit;
        if (irq_clear) begin
            next_standby = 1'b0;
        end else if (sleep_wr) begin
            next_standby = pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_bit <= 1'b0;
        end else begin
            standby_bit <= next_standby;
        end
    end

    // The clear on interrupt acts before the vector fetch in that cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_reset <= 1'b0;
        end else begin
            standby_reset <= standby_bit && !irq_clear &&
                             flash_touch;
        end
    end

    // Read data
    logic [7:0] mirror;
    logic [7:0] ctrl_view;

    always_comb begin
        mirror = 8'h00;
        mirror[fgam_pkg::MIR_GUARD_BIT] = guard_on;
        mirror[fgam_pkg::BOOT_BIT] = boot_on;
        mirror[fgam_pkg::AREA_HI:fgam_pkg::AREA_LO] = area_act;
        mirror[1:0] = ctrl_act[1:0];
    end

    always_comb begin
        ctrl_view = ctrl_hold;
        if (serial_mode) begin
            ctrl_view[fgam_pkg::BOOT_BIT] = 1'b1;
        end
    end

    // Sleep control and both commit registers are write-only: read zero
    // except that the flash commit address shows the active mirror.
    always_comb begin
        prdata = 32'h00000000;
        if (sel_ctrl) begin
            prdata[7:0] = ctrl_view;
        end else if (sel_commit) begin
            prdata[7:0] = mirror;
        end else if (sel_sys) begin
            prdata[1:0] = sys_hold;
        end else if (sel_sleep) begin
            prdata[7:0] = 8'h00;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/fgam_pkg.sv ----
// Package with register map, field layout and keys of the flash guard block
package fgam_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [13:0] IDX_CTRL_ONE = 14'h0fd0;
    localparam logic [13:0] IDX_COMMIT = 14'h0fd1;
    localparam logic [13:0] IDX_SLEEP_CTRL = 14'h0fd2;
    localparam logic [13:0] IDX_SYS_CFG_THREE = 14'h0fd8;
    localparam logic [13:0] IDX_SYS_COMMIT = 14'h0fd9;

    localparam logic [7:0] FLASH_KEY = 8'hd5;
    localparam logic [7:0] SYS_KEY = 8'hd4;

    localparam logic [2:0] GUARD_ON = 3'h5;
    localparam logic [2:0] GUARD_OFF = 3'h2;
    localparam logic [1:0] AREA_STD = 2'h0;
    localparam logic [1:0] AREA_CODE = 2'h2;

    // Field positions in flash_ctrl_one
    localparam int GUARD_HI = 7;
    localparam int GUARD_LO = 5;
    localparam int BOOT_BIT = 4;
    localparam int AREA_HI = 3;
    localparam int AREA_LO = 2;
    // Field positions in flash_ctrl_mirror
    localparam int MIR_GUARD_BIT = 5;
    // Field positions in system_cfg_three
    localparam int RAM_MAP_BIT = 0;
    localparam int VEC_RAM_BIT = 1;
    // Bit that toggles on reads while flash is busy
    localparam int TOGGLE_BIT = 6;

    localparam logic [7:0] CTRL_ONE_RST = 8'h40;
    localparam logic [1:0] SYS_CFG_RST = 2'h0;

    // Address windows
    localparam logic [15:0] FLASH_LO = 16'h8000;
    localparam logic [15:0] FLASH_HI = 16'hffff;
    localparam logic [15:0] BOOT_LO = 16'h1000;
    localparam logic [15:0] BOOT_HI = 16'h17ff;
    localparam logic [15:0] BOOT_SER_CODE_HI = 16'h1fff;
    localparam logic [15:0] RAM_CODE_LO = 16'h0040;
    localparam logic [15:0] RAM_CODE_HI = 16'h0fff;
endpackage

// ---- rtl/fgam_shadow_reg.sv ----
// Double-buffered control register: holding copy plus committed active copy
`timescale 1ns/1ps
`default_nettype none
module fgam_shadow_reg #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_hold,
    input wire logic [W-1:0] hold_in,
    input wire logic commit,
    output logic [W-1:0] hold,
    output logic [W-1:0] active
);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold <= RST;
        end else if (wr_hold) begin
            hold <= hold_in;
        end
    end

    // A write and a commit in one cycle commit the old holding value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            active <= RST;
        end else if (commit) begin
            active <= hold;
        end
    end
endmodule
`default_nettype wire

// ---- tb/fgam_flash_guard_props.sv ----
// Port-level assertions for the flash guard block
`timescale 1ns/1ps
`default_nettype none
module fgam_guard_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic serial_mode,
    input wire logic exec_from_ram,
    input wire logic irq_vector_fetch,
    input wire logic code_req,
    input wire logic [15:0] code_addr,
    input wire logic code_to_flash,
    input wire logic code_to_boot,
    input wire logic code_to_ram,
    input wire logic data_req,
    input wire logic data_we,
    input wire logic [15:0] data_addr,
    input wire logic data_to_flash,
    input wire logic flash_cmd_we,
    input wire logic [15:0] flash_cmd_addr,
    input wire logic guard_enabled,
    input wire logic standby_bit,
    input wire logic standby_reset
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_gated_wr;
        data_req && data_we && data_to_flash && guard_enabled;
    endsequence
    AST_CMD_PASS: assert property (s_gated_wr |=> flash_cmd_we
        && flash_cmd_addr == $past(data_addr)) else $error("command lost");
    AST_CMD_GUARD: assert property (flash_cmd_we |-> $past(guard_enabled))
        else $error("command passed while guarded");
    AST_CMD_DATA_ONLY: assert property (!(data_req && data_we)
        |=> !flash_cmd_we) else $error("command without data write");
    AST_SER_RAM: assert property (serial_mode && code_req
        && code_addr inside {[16'h0040:16'h0fff]} |-> code_to_ram)
        else $error("serial mode RAM not mapped");
    AST_SER_BOOT: assert property (serial_mode && code_req
        && code_addr inside {[16'h1000:16'h1fff]}
        |-> code_to_boot && !code_to_flash) else $error("serial boot missing");
    AST_STBY_RST: assert property (standby_bit && !irq_vector_fetch
        && (code_to_flash || data_to_flash) |=> standby_reset)
        else $error("standby reset missing");
    AST_STBY_LOCK: assert property (s_acc ##0 (pwrite && !exec_from_ram
        && paddr == 16'h3f48 && !irq_vector_fetch) |=> $stable(standby_bit))
        else $error("standby bit changed from flash code");
    AST_SLEEP_RD: assert property (s_acc ##0 (!pwrite
        && paddr == 16'h3f48) |-> prdata == 32'h0)
        else $error("standby register read not zero");
endmodule
bind fgam_flash_guard fgam_guard_chk i_fgam_guard_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .serial_mode(serial_mode),
    .exec_from_ram(exec_from_ram), .irq_vector_fetch(irq_vector_fetch),
    .code_req(code_req), .code_addr(code_addr), .code_to_ram(code_to_ram),
    .code_to_flash(code_to_flash), .code_to_boot(code_to_boot),
    .data_req(data_req), .data_we(data_we), .data_addr(data_addr),
    .data_to_flash(data_to_flash), .flash_cmd_we(flash_cmd_we),
    .flash_cmd_addr(flash_cmd_addr), .guard_enabled(guard_enabled),
    .standby_bit(standby_bit), .standby_reset(standby_reset));
`default_nettype wire

// ---- tb/fgam_flash_model.sv ----
// Flash array and command engine stand-in
`timescale 1ns/1ps
`default_nettype none
module fgam_flash_model #(
    parameter int BUSY_CYCLES = 40,
    parameter logic [7:0] RD_VAL = 8'h3c
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flash_cmd_we,
    output logic [7:0] flash_rdata,
    output logic flash_busy
);
    int unsigned left;
    // A started program keeps running even if the guard drops meanwhile
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left <= 0;
        end else if (flash_cmd_we) begin
            left <= BUSY_CYCLES;
        end else if (left != 0) begin
            left <= left - 1;
        end
    end
    assign flash_busy = (left != 0);
    assign flash_rdata = RD_VAL;
endmodule
`default_nettype wire

// ---- tb/tb_flash_guard_and_area_map.sv ----
// Self-checking bench for the flash guard block
`timescale 1ns/1ps
`default_nettype none
module tb_flash_guard_and_area_map;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0, code_addr = 16'h0, data_addr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, err, we_seen, rv_seen, sr_seen;
    logic serial_mode = 1'b0, exec_from_ram = 1'b0, irq_vector_fetch = 1'b0;
    logic code_req = 1'b0, data_req = 1'b0, data_we = 1'b0;
    logic [7:0] data_wdata = 8'h0, data_rdata, flash_rdata, flash_cmd_data, rd;
    logic code_to_flash, code_to_boot, code_to_ram, data_to_flash, data_to_boot;
    logic data_rvalid, flash_busy, flash_cmd_we, flash_code_win;
    logic guard_enabled, standby_bit, standby_reset;
    logic [15:0] flash_cmd_addr;
    logic [1:0] ds;
    logic [2:0] cs;
    int bad_count = 0, total_checks = 0;
    localparam logic [15:0] A_CTRL = 16'(fgam_pkg::IDX_CTRL_ONE * 4);
    localparam logic [15:0] A_COMMIT = 16'(fgam_pkg::IDX_COMMIT * 4);
    localparam logic [15:0] A_SLEEP = 16'(fgam_pkg::IDX_SLEEP_CTRL * 4);
    localparam logic [15:0] A_CFG = 16'(fgam_pkg::IDX_SYS_CFG_THREE * 4);
    localparam logic [15:0] A_SYSC = 16'(fgam_pkg::IDX_SYS_COMMIT * 4);
    always #25 pclk = ~pclk;
    fgam_flash_guard i_fgam_flash_guard (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_mode(serial_mode), .exec_from_ram(exec_from_ram),
        .irq_vector_fetch(irq_vector_fetch), .code_req(code_req),
        .code_addr(code_addr), .code_to_flash(code_to_flash),
        .code_to_boot(code_to_boot), .code_to_ram(code_to_ram),
        .data_req(data_req), .data_we(data_we), .data_addr(data_addr),
        .data_wdata(data_wdata), .data_to_flash(data_to_flash),
        .data_to_boot(data_to_boot), .data_rdata(data_rdata),
        .data_rvalid(data_rvalid), .flash_rdata(flash_rdata),
        .flash_busy(flash_busy), .flash_cmd_we(flash_cmd_we),
        .flash_cmd_addr(flash_cmd_addr), .flash_cmd_data(flash_cmd_data),
        .flash_code_win(flash_code_win), .guard_enabled(guard_enabled),
        .standby_bit(standby_bit), .standby_reset(standby_reset));
    fgam_flash_model i_fgam_flash_model (.pclk(pclk), .presetn(presetn),
        .flash_cmd_we(flash_cmd_we), .flash_rdata(flash_rdata),
        .flash_busy(flash_busy));
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rv = prdata;
        err = pslverr;
        if (n >= 50) bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic cfg(input logic [7:0] v);
        apb(1'b1, A_CTRL, {24'h0, v});
        apb(1'b1, A_COMMIT, {24'h0, fgam_pkg::FLASH_KEY});
    endtask
    task automatic dacc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge pclk);
        data_req <= 1'b1;
        data_we <= w;
        data_addr <= a;
        data_wdata <= d;
        @(negedge pclk);
        ds = {data_to_flash, data_to_boot};
        @(posedge pclk);
        data_req <= 1'b0;
        @(negedge pclk);
        we_seen = flash_cmd_we;
        rv_seen = data_rvalid;
        sr_seen = standby_reset;
        rd = data_rdata;
    endtask
    task automatic cf(input logic [15:0] a);
        @(posedge pclk);
        code_req <= 1'b1;
        code_addr <= a;
        @(negedge pclk);
        cs = {code_to_flash, code_to_boot, code_to_ram};
        @(posedge pclk);
        code_req <= 1'b0;
    endtask
    task automatic irq;
        @(posedge pclk);
        irq_vector_fetch <= 1'b1;
        @(posedge pclk);
        irq_vector_fetch <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge pclk);
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_CTRL, 32'h0);
        ck(rv, 32'h40);
        apb(1'b0, A_COMMIT, 32'h0);
        ck(rv, 32'h0);
        apb(1'b0, 16'h3f4c, 32'h0);
        ck(err, 32'h1);
        dacc(1'b1, 16'h8555, 8'haa);
        ck(we_seen, 32'h0);
        apb(1'b1, A_CTRL, 32'ha0);
        ck(guard_enabled, 32'h0);
        apb(1'b1, A_COMMIT, 32'h12);
        ck(guard_enabled, 32'h0);
        apb(1'b1, A_COMMIT, {24'h0, fgam_pkg::FLASH_KEY});
        ck(guard_enabled, 32'h1);
        apb(1'b0, A_COMMIT, 32'h0);
        ck(rv, 32'h20);
        $display("guard test done");
        // One program into an erased cell, through the data window only
        dacc(1'b1, 16'h8555, 8'haa);
        ck(we_seen, 32'h1);
        ck({flash_cmd_addr, flash_cmd_data}, 32'h8555aa);
        dacc(1'b0, 16'h8000, 8'h0);
        ck({rv_seen, rd}, 32'h13c);
        dacc(1'b0, 16'h8000, 8'h0);
        ck({rv_seen, rd}, 32'h17c);
        // Close the guard here only after the array goes idle
        while (flash_busy) @(posedge pclk);
        @(negedge pclk);
        cfg(8'h40);
        dacc(1'b1, 16'h8aaa, 8'h55);
        ck(we_seen, 32'h0);
        $display("command test done");
        cfg(8'h48);
        ck(flash_code_win, 32'h1);
        cfg(8'h40);
        ck(flash_code_win, 32'h0);
        cfg(8'h50);
        cf(16'h17ff);
        ck(cs, 32'h2);
        dacc(1'b0, 16'h1000, 8'h0);
        ck(ds, 32'h1);
        cfg(8'h40);
        cf(16'h17ff);
        ck(cs, 32'h0);
        $display("area test done");
        apb(1'b1, A_CFG, 32'h1);
        apb(1'b1, A_SYSC, 32'h0);
        cf(16'h0040);
        ck(cs, 32'h0);
        apb(1'b1, A_SYSC, {24'h0, fgam_pkg::SYS_KEY});
        cf(16'h0040);
        ck(cs, 32'h1);
        apb(1'b1, A_CFG, 32'h0);
        apb(1'b1, A_SYSC, {24'h0, fgam_pkg::SYS_KEY});
        cf(16'h0040);
        ck(cs, 32'h0);
        $display("ram map test done");
        @(posedge pclk);
        serial_mode <= 1'b1;
        cf(16'h1fff);
        ck(cs, 32'h2);
        cf(16'h0100);
        ck(cs, 32'h1);
        dacc(1'b0, 16'h1700, 8'h0);
        ck(ds, 32'h1);
        apb(1'b1, A_CTRL, 32'h40);
        apb(1'b0, A_CTRL, 32'h0);
        ck(rv, 32'h50);
        @(posedge pclk);
        serial_mode <= 1'b0;
        $display("serial test done");
        apb(1'b1, A_SLEEP, 32'h1);
        ck(standby_bit, 32'h0);
        @(posedge pclk);
        exec_from_ram <= 1'b1;
        apb(1'b1, A_SLEEP, 32'h1);
        ck(standby_bit, 32'h1);
        apb(1'b0, A_SLEEP, 32'h0);
        ck(rv, 32'h0);
        dacc(1'b0, 16'h8000, 8'h0);
        ck(sr_seen, 32'h1);
        irq();
        ck(standby_bit, 32'h0);
        apb(1'b1, A_SLEEP, 32'h1);
        apb(1'b1, A_CFG, 32'h2);
        apb(1'b1, A_SYSC, {24'h0, fgam_pkg::SYS_KEY});
        irq();
        ck(standby_bit, 32'h1);
        apb(1'b1, A_SLEEP, 32'h0);
        ck(standby_bit, 32'h0);
        $display("standby test done");
        stop_test();
    end
endmodule
`default_nettype wire
